// ---- hw/sf_align_pkg.sv ----
package sf_align_pkg;

  // Frame geometry: one F-bit plus 24 channels of 8 bits
  localparam int CHANNELS = 24;
  localparam int CHANNEL_BITS = 8;
  localparam int FRAME_BITS = 1 + CHANNELS * CHANNEL_BITS;
  localparam logic [7:0] FBIT_POS = 8'h00;
  localparam logic [7:0] LAST_BIT_POS = 8'(FRAME_BITS - 1);

  // Superframe of 12 frames and its F-bit pattern, frame 1 in the MSB
  localparam int SF_FRAMES = 12;
  localparam logic [3:0] FIRST_FRAME_IDX = 4'h0;
  localparam logic [3:0] LAST_FRAME_IDX = 4'(SF_FRAMES - 1);
  localparam logic [11:0] SF_PATTERN = 12'h8dc;
  localparam logic [11:0] J1_DONT_CARE = 12'h001;
  localparam logic [11:0] NO_DONT_CARE = 12'h000;

  // Search limits, counted in F-bit samples
  localparam logic [4:0] PATTERN_LAST_SAMPLE = 5'h0b;
  localparam logic [4:0] HUNT_LAST_SAMPLE = 5'h17;

  // Out-of-frame: this many errors among the last four F-bits
  localparam int OOF_ERR_LIMIT = 2;

  // Mimic watcher starts one bit after the candidate F-bit
  localparam logic [7:0] MIMIC_FIRST_OFF = 8'h01;

  // Input buffer
  localparam int FIFO_WIDTH = 1;
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [3:0] {
    st_hunt = 4'h1,
    st_confirm = 4'h2,
    st_sync = 4'h4,
    st_bypass = 4'h8
  } align_state_t;

endpackage

// ---- hw/sf_bit_fifo.sv ----
`timescale 1ns/10ps
module sf_bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  output logic [WIDTH-1:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;

  // Flags and handshakes; pointers wrap naturally, DEPTH is a power of two
  assign full = (count_reg == (AW+1)'(DEPTH));
  assign empty = (count_reg == '0);
  assign wr_ready_out = ~full;
  assign rd_valid_out = ~empty;
  assign push = wr_valid_in & ~full;
  assign pop = rd_ready_in & ~empty;
  assign rd_data_out = mem[rd_ptr_reg];

  // Storage, no reset needed
  always_ff @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + AW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

endmodule // sf_bit_fifo

// ---- hw/t1_superframe_alignment_search.sv ----
`timescale 1ns/10ps
// Function
// - Superframe is 12 frames, each one F-bit then 24 eight-bit channels.
// - Hunt F-bits for 100011011100 in T1, last bit ignored in J1.
// - Same pattern seen at a non F-bit position counts as a mimic.
// - Mimic check on: sync after two clean patterns and no mimic.
// - Mimic check off: sync after two clean patterns, mimics ignored.
// - Raise the mimic flag whenever a mimic is seen during search.
// - Out-of-frame status is 0 while in sync, 1 otherwise.
// - Mark the first bit of every superframe while in sync.
// - In sync keep checking F-bits, flag errors, drop sync on errors.
// - Bypass control disables all alignment processing.
// - In T1 the last pattern bit must be 0; in J1 either value.
module t1_superframe_alignment_search
  import sf_align_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic line_bit_in,
  input wire logic line_valid_in,
  output logic line_ready_out,
  input wire logic j1_mode_in,
  input wire logic mimic_check_enable_in,
  input wire logic framer_bypass_in,
  input wire logic mimic_clear_in,
  output logic data_bit_out,
  output logic data_valid_out,
  input wire logic data_ready_in,
  output logic framing_bit_flag_out,
  output logic multiframe_boundary_flag_out,
  output logic framing_error_out,
  output logic out_of_frame_status_out,
  output logic mimic_present_flag_out
);

  // Finds the superframe phase of a 12-sample history: {hit, phase}
  function automatic logic [4:0] rot_match(input logic [11:0] seq,
                                           input logic [11:0] dc);
    logic [23:0] pp;
    logic [23:0] mm;
    logic [11:0] w;
    logic [11:0] m;
    logic hit;
    logic [3:0] k;
    pp = {SF_PATTERN, SF_PATTERN};
    mm = {dc, dc};
    hit = 1'b0;
    k = FIRST_FRAME_IDX;
    for (int i = 0; i < SF_FRAMES; i++) begin
      w = pp[23-i -: 12];
      m = mm[23-i -: 12];
      if (!hit && (((seq ^ w) & ~m) == 12'h000)) begin
        hit = 1'b1;
        k = 4'(i);
      end
    end
    return {hit, k};
  endfunction

  align_state_t state_reg, state_next;
  logic [7:0] bit_pos_reg, bit_pos_next;
  logic [4:0] samp_cnt_reg, samp_cnt_next;
  logic [11:0] fbit_shift_reg, fbit_shift_next;
  logic [3:0] frame_idx_reg, frame_idx_next;
  logic [3:0] err_hist_reg, err_hist_next;
  logic [7:0] mimic_pos_reg;
  logic [11:0] mimic_shift_reg;
  logic [3:0] mimic_cnt_reg;
  logic mimic_seen_reg;
  logic mimic_flag_reg;
  logic out_valid_reg;
  logic data_bit_reg;
  logic fbit_flag_reg;
  logic mfb_flag_reg;
  logic ferr_reg;
  logic slip;
  logic enter_confirm;

  logic fifo_bit;
  logic fifo_valid;
  logic fifo_ready;
  logic take;
  logic [11:0] dc_mask;
  logic is_fbit;
  logic fbit_take;
  logic searching;
  logic [11:0] fbit_shift_new;
  logic [4:0] hunt_rot;
  logic hunt_hit;
  logic exp_bit;
  logic dc_bit;
  logic fbit_ok;
  logic [3:0] frame_idx_inc;
  logic [3:0] err_hist_new;
  logic oof_trip;
  logic mimic_sample;
  logic [11:0] mimic_shift_new;
  logic [4:0] mimic_rot;
  logic mimic_hit;
  logic mimic_wrap;

  // Input buffer, drained one bit per accepted output slot
  sf_bit_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .wr_data_in(line_bit_in),
    .wr_valid_in(line_valid_in),
    .wr_ready_out(line_ready_out),
    .rd_data_out(fifo_bit),
    .rd_valid_out(fifo_valid),
    .rd_ready_in(fifo_ready)
  );

  // Output stage stalls the buffer when downstream holds back
  assign fifo_ready = ~out_valid_reg | data_ready_in;
  assign take = fifo_valid & fifo_ready;

  // Position decode; no F-bit exists in bypass
  assign is_fbit = (bit_pos_reg == FBIT_POS) &&
                   (state_reg != st_bypass);
  assign fbit_take = take & is_fbit;
  assign searching = (state_reg == st_hunt) || (state_reg == st_confirm);
  assign dc_mask = j1_mode_in ? J1_DONT_CARE : NO_DONT_CARE;

  // Hunt over the last 12 F-bit samples at the candidate position
  assign fbit_shift_new = {fbit_shift_reg[10:0], fifo_bit};
  assign hunt_rot = rot_match(fbit_shift_new, dc_mask);
  assign hunt_hit = hunt_rot[4] && (samp_cnt_reg >= PATTERN_LAST_SAMPLE);

  // Expected F-bit for the tracked frame number
  assign exp_bit = SF_PATTERN[LAST_FRAME_IDX - frame_idx_reg];
  assign dc_bit = dc_mask[LAST_FRAME_IDX - frame_idx_reg];
  assign fbit_ok = (fifo_bit == exp_bit) | dc_bit;
  assign frame_idx_inc = (frame_idx_reg == LAST_FRAME_IDX) ?
                         FIRST_FRAME_IDX : frame_idx_reg + 4'h1;

  // Error window for losing sync
  assign err_hist_new = {err_hist_reg[2:0], ~fbit_ok};
  assign oof_trip = ($countones(err_hist_new) >= OOF_ERR_LIMIT);

  // Mimic watcher samples one other bit position per 12 frames
  assign mimic_sample = take && searching &&
                        (bit_pos_reg == mimic_pos_reg);
  assign mimic_shift_new = {mimic_shift_reg[10:0], fifo_bit};
  assign mimic_rot = rot_match(mimic_shift_new, dc_mask);
  assign mimic_wrap = mimic_sample && (mimic_cnt_reg == LAST_FRAME_IDX);
  assign mimic_hit = mimic_wrap && mimic_rot[4];

  // Alignment state machine, acts on each F-bit taken
  always_comb begin
    state_next = state_reg;
    samp_cnt_next = samp_cnt_reg;
    fbit_shift_next = fbit_shift_reg;
    frame_idx_next = frame_idx_reg;
    err_hist_next = err_hist_reg;
    slip = 1'b0;
    enter_confirm = 1'b0;
    case (state_reg)
      st_hunt: begin
        if (fbit_take) begin
          fbit_shift_next = fbit_shift_new;
          if (hunt_hit) begin
            state_next = st_confirm;
            enter_confirm = 1'b1;
            frame_idx_next = hunt_rot[3:0];
            samp_cnt_next = '0;
          end else if (samp_cnt_reg == HUNT_LAST_SAMPLE) begin
            slip = 1'b1;
            samp_cnt_next = '0;
          end else begin
            samp_cnt_next = samp_cnt_reg + 5'h01;
          end
        end
      end
      st_confirm: begin
        if (fbit_take) begin
          frame_idx_next = frame_idx_inc;
          samp_cnt_next = samp_cnt_reg + 5'h01;
          if (!fbit_ok) begin
            state_next = st_hunt;
            slip = 1'b1;
            samp_cnt_next = '0;
          end else if (samp_cnt_reg == PATTERN_LAST_SAMPLE) begin
            samp_cnt_next = '0;
            if (mimic_check_enable_in && (mimic_seen_reg || mimic_hit)) begin
              state_next = st_hunt;
              slip = 1'b1;
            end else begin
              state_next = st_sync;
              err_hist_next = '0;
            end
          end
        end
      end
      st_sync: begin
        if (fbit_take) begin
          frame_idx_next = frame_idx_inc;
          err_hist_next = err_hist_new;
          if (oof_trip) begin
            state_next = st_hunt;
            samp_cnt_next = '0;
          end
        end
      end
      st_bypass: begin
        if (!framer_bypass_in) begin
          state_next = st_hunt;
          samp_cnt_next = '0;
        end
      end
      default: begin
        state_next = st_hunt;
      end
    endcase
    if (framer_bypass_in) begin
      state_next = st_bypass;
    end
  end

  // Bit counter; a slip holds it so the candidate moves one bit later
  assign bit_pos_next = !take ? bit_pos_reg :
                        slip ? bit_pos_reg :
                        (bit_pos_reg == LAST_BIT_POS) ? FBIT_POS :
                        bit_pos_reg + 8'h01;

  // Alignment state registers
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_reg <= st_hunt;
      bit_pos_reg <= FBIT_POS;
      samp_cnt_reg <= '0;
      fbit_shift_reg <= '0;
      frame_idx_reg <= FIRST_FRAME_IDX;
      err_hist_reg <= '0;
    end else begin
      state_reg <= state_next;
      bit_pos_reg <= bit_pos_next;
      samp_cnt_reg <= samp_cnt_next;
      fbit_shift_reg <= fbit_shift_next;
      frame_idx_reg <= frame_idx_next;
      err_hist_reg <= err_hist_next;
    end
  end

  // Mimic watcher position and history
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mimic_pos_reg <= MIMIC_FIRST_OFF;
      mimic_shift_reg <= '0;
      mimic_cnt_reg <= FIRST_FRAME_IDX;
    end else if (mimic_sample) begin
      mimic_shift_reg <= mimic_shift_new;
      if (mimic_wrap) begin
        mimic_cnt_reg <= FIRST_FRAME_IDX;
        mimic_pos_reg <= (mimic_pos_reg == LAST_BIT_POS) ?
                         MIMIC_FIRST_OFF : mimic_pos_reg + 8'h01;
      end else begin
        mimic_cnt_reg <= mimic_cnt_reg + 4'h1;
      end
    end
  end

  // Mimic flags; a new mimic wins over a clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mimic_seen_reg <= 1'b0;
      mimic_flag_reg <= 1'b0;
    end else begin
      if (mimic_hit) begin
        mimic_seen_reg <= 1'b1;
      end else if (enter_confirm) begin
        mimic_seen_reg <= 1'b0;
      end
      if (mimic_hit) begin
        mimic_flag_reg <= 1'b1;
      end else if (mimic_clear_in) begin
        mimic_flag_reg <= 1'b0;
      end
    end
  end

  // Output word: the bit and its markers travel together
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      out_valid_reg <= 1'b0;
      data_bit_reg <= 1'b0;
      fbit_flag_reg <= 1'b0;
      mfb_flag_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else if (take) begin
      out_valid_reg <= 1'b1;
      data_bit_reg <= fifo_bit;
      fbit_flag_reg <= is_fbit;
      mfb_flag_reg <= is_fbit && (state_reg == st_sync) &&
                      (frame_idx_reg == FIRST_FRAME_IDX);
      ferr_reg <= is_fbit && (state_reg == st_sync) && !fbit_ok;
    end else if (data_ready_in) begin
      out_valid_reg <= 1'b0;
    end
  end

  assign data_bit_out = data_bit_reg;
  assign data_valid_out = out_valid_reg;
  assign framing_bit_flag_out = fbit_flag_reg;
  assign multiframe_boundary_flag_out = mfb_flag_reg;
  assign framing_error_out = ferr_reg;
  assign out_of_frame_status_out = (state_reg != st_sync);
  assign mimic_present_flag_out = mimic_flag_reg;

endmodule // t1_superframe_alignment_search

// ---- tb/sf_align_assertions.sv ----
`timescale 1ns/10ps
module sf_align_checker (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic framer_bypass_in,
  input wire logic mimic_clear_in,
  input wire logic data_ready_in,
  input wire logic data_valid_out,
  input wire logic data_bit_out,
  input wire logic framing_bit_flag_out,
  input wire logic multiframe_boundary_flag_out,
  input wire logic framing_error_out,
  input wire logic out_of_frame_status_out,
  input wire logic mimic_present_flag_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic moved_reg;
  // High when the output word may have been replaced at the last edge
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      moved_reg <= 1'b1;
    end else begin
      moved_reg <= !data_valid_out || data_ready_in;
    end
  end
  oof_start_a: assert property (
    $rose(rstn_in) |-> out_of_frame_status_out)
    else $error("out of frame not set after reset");
  bypass_oof_a: assert property (
    framer_bypass_in |=> out_of_frame_status_out)
    else $error("bypass did not force out of frame");
  bypass_flags_a: assert property (
    framer_bypass_in [*4] ##0 data_valid_out && moved_reg |->
    !(framing_bit_flag_out || multiframe_boundary_flag_out))
    else $error("framing flag on a bypassed word");
  boundary_fbit_a: assert property (
    multiframe_boundary_flag_out |-> framing_bit_flag_out)
    else $error("boundary flag on a non framing bit");
  boundary_sync_a: assert property (
    multiframe_boundary_flag_out && moved_reg |->
    !$past(out_of_frame_status_out))
    else $error("boundary flag while out of frame");
  error_fbit_a: assert property (
    framing_error_out |-> framing_bit_flag_out)
    else $error("framing error on a non framing bit");
  mimic_hold_a: assert property (
    mimic_present_flag_out && !mimic_clear_in |=> mimic_present_flag_out)
    else $error("mimic flag dropped without clear");
  mimic_set_a: assert property (
    $rose(mimic_present_flag_out) |-> $past(out_of_frame_status_out))
    else $error("mimic flag set while in sync");
  word_stall_a: assert property (
    data_valid_out && !data_ready_in |=> data_valid_out &&
    $stable(data_bit_out) && $stable(multiframe_boundary_flag_out))
    else $error("stalled word changed");
  cover property ($fell(out_of_frame_status_out));
  cover property (multiframe_boundary_flag_out && data_ready_in);
  cover property (framing_error_out && data_ready_in);
  cover property ($rose(mimic_present_flag_out));
endmodule // sf_align_checker

// ---- tb/line_decoder_model.sv ----
`timescale 1ns/10ps
module line_decoder_model
  import sf_align_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic gap_in,
  input wire logic [11:0] err_mask_in,
  input wire logic mimic_in,
  input wire logic line_ready_in,
  output logic line_bit_out,
  output logic line_valid_out
);
  int idx;
  logic [7:0] pos;
  logic [3:0] sel;
  logic bit_now;
  // Frame n carries pattern bit n, first frame in the MSB, flipped if masked;
  // with mimic on, the bit after each F-bit copies the clean pattern
  assign pos = 8'(idx % FRAME_BITS);
  assign sel = 4'hb - 4'((idx / FRAME_BITS) % SF_FRAMES);
  assign bit_now = (pos == FBIT_POS) ? SF_PATTERN[sel] ^ err_mask_in[sel] :
    (mimic_in && pos == MIMIC_FIRST_OFF) ? SF_PATTERN[sel] :
    pos[1] ^ pos[3];
  // An idle line shows the inverse, never the next bit
  assign line_bit_out = line_valid_out ? bit_now : ~bit_now;
  // Offer held until taken; gap mode idles one cycle after each bit
  always @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      idx <= 0;
      line_valid_out <= 1'b0;
    end else begin
      if (line_valid_out && line_ready_in) idx <= #1 idx + 1;
      if (!line_valid_out || line_ready_in)
        line_valid_out <= #1 run_in && !(gap_in && line_valid_out);
    end
  end
endmodule // line_decoder_model

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import sf_align_pkg::*;
  localparam int SF_BITS = FRAME_BITS * SF_FRAMES;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic run = 1'b0, gap = 1'b0, j1 = 1'b0, mck = 1'b0, byp = 1'b0;
  logic clr = 1'b0, dready = 1'b1, mimic = 1'b0;
  logic [11:0] mask = 12'h000;
  logic lbit, lvalid, lready, dbit, dvalid, fbf, mbf, ferr, oof, mim;
  int num_errors = 0, tests_run = 0, out_idx = 0, taken = 0;
  int mf_seen = 0, err_seen = 0, flag_seen = 0;
  always #5 core_clk_in = ~core_clk_in;
  line_decoder_model line_decoder_model_i (.core_clk_in(core_clk_in),
    .rstn_in(rstn_in), .run_in(run), .gap_in(gap), .err_mask_in(mask),
    .line_ready_in(lready), .mimic_in(mimic), .line_bit_out(lbit),
    .line_valid_out(lvalid));
  t1_superframe_alignment_search t1_superframe_alignment_search_i (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .line_bit_in(lbit),
    .line_valid_in(lvalid), .line_ready_out(lready), .j1_mode_in(j1),
    .mimic_check_enable_in(mck), .framer_bypass_in(byp),
    .mimic_clear_in(clr), .data_bit_out(dbit), .data_valid_out(dvalid),
    .data_ready_in(dready), .framing_bit_flag_out(fbf),
    .multiframe_boundary_flag_out(mbf), .framing_error_out(ferr),
    .out_of_frame_status_out(oof), .mimic_present_flag_out(mim));
  // Expected payload bit; with mimic on the bit after the F-bit is the pattern
  function automatic logic pay(input int i, input logic mim_on);
    logic [7:0] p;
    p = 8'(i % FRAME_BITS);
    if (mim_on && p == MIMIC_FIRST_OFF) begin
      return SF_PATTERN[LAST_FRAME_IDX - 4'((i / FRAME_BITS) % SF_FRAMES)];
    end
    return p[1] ^ p[3];
  endfunction
  task automatic check(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
      num_errors++;
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask
  task automatic wait_oof(input logic val, input int bound);
    int n;
    n = 0;
    while (oof !== val && n < bound) begin
      tick(1);
      n++;
    end
    check("out_of_frame_status", val, oof);
    if (oof !== val) conclude();
  endtask
  // Mid-run reset; mimic and mimic check change only while reset is held
  task automatic restart(input logic mim_on, input logic chk);
    rstn_in = 1'b0;
    mimic = mim_on;
    mck = chk;
    tick(2);
    check("oof_after_reset", 1'b1, oof);
    rstn_in = 1'b1;
  endtask
  // Output side: payload order and flag positions on every accepted word
  always @(negedge core_clk_in) begin
    if (!rstn_in) out_idx = 0;
    if (rstn_in && lvalid && lready) taken++;
    if (rstn_in && dvalid && dready) begin
      if (out_idx % FRAME_BITS != 0) begin
        check("data_bit", pay(out_idx, mimic), dbit);
      end
      if (fbf && !oof) begin
        check("fbit_pos", 1'b1, out_idx % FRAME_BITS == 0);
      end
      if (mbf) begin
        check("boundary_pos", 1'b1, out_idx % SF_BITS == 0);
      end
      mf_seen += int'(mbf);
      err_seen += int'(ferr);
      flag_seen += int'(fbf | mbf | ferr);
      out_idx++;
    end
  end
  task automatic t_sync();
    run = 1'b1;
    wait_oof(1'b0, 12000);
    tick(5000);
    check("boundary_count", 1'b1, mf_seen >= 2);
    check("mimic_flag", 1'b0, mim);
  endtask
  task automatic t_fill();
    int base;
    run = 1'b0;
    tick(30);
    dready = 1'b0;
    run = 1'b1;
    base = taken;
    tick(40);
    check("line_ready_full", 1'b0, lready);
    check("bits_taken_full", 1'b1, taken - base == 17);
    dready = 1'b1;
    gap = 1'b1;
    tick(3000);
    check("line_ready_drained", 1'b1, lready);
    check("oof_slow_feed", 1'b0, oof);
    gap = 1'b0;
  endtask
  task automatic t_errors();
    int n;
    mask = 12'h100;
    err_seen = 0;
    n = 0;
    while (err_seen == 0 && n < 3000) begin
      tick(1);
      n++;
    end
    check("framing_error_seen", 1'b1, err_seen > 0);
    if (err_seen == 0) conclude();
    check("oof_single_error", 1'b0, oof);
    mask = 12'h300;
    wait_oof(1'b1, 5000);
    mask = 12'h000;
    mck = 1'b1;
    wait_oof(1'b0, 12000);
    mck = 1'b0;
  endtask
  task automatic t_j1();
    j1 = 1'b1;
    mask = 12'h001;
    err_seen = 0;
    tick(5000);
    check("j1_last_bit_errors", 1'b1, err_seen == 0);
    check("oof_j1", 1'b0, oof);
    j1 = 1'b0;
    tick(5000);
    check("t1_last_bit_errors", 1'b1, err_seen > 0);
  endtask
  task automatic t_bypass();
    byp = 1'b1;
    tick(2);
    check("oof_bypass", 1'b1, oof);
    tick(10);
    flag_seen = 0;
    tick(2000);
    check("flags_in_bypass", 1'b1, flag_seen == 0);
    byp = 1'b0;
    tick(6000);
    check("oof_t1_bad_last_bit", 1'b1, oof);
    mask = 12'h000;
    restart(1'b0, 1'b0);
    wait_oof(1'b0, 12000);
    check("mimic_flag_clean", 1'b0, mim);
  endtask
  // Mimic one bit after the F-bit: ignored unchecked, blocks sync when checked
  task automatic t_mimic();
    restart(1'b1, 1'b0);
    wait_oof(1'b0, 12000);
    check("mimic_flag_set", 1'b1, mim);
    clr = 1'b1;
    tick(1);
    check("mimic_cleared", 1'b0, mim);
    clr = 1'b0;
    restart(1'b1, 1'b1);
    tick(4700);
    check("mimic_flag_search", 1'b1, mim);
    check("oof_mimic_blocked", 1'b1, oof);
  endtask
  // Main sequence: reset for two cycles, then each scenario in turn
  initial begin
    tick(1);
    check("oof_in_reset", 1'b1, oof);
    check("valid_in_reset", 1'b0, dvalid);
    tick(1);
    rstn_in = 1'b1;
    t_sync();
    t_fill();
    t_errors();
    t_j1();
    t_bypass();
    t_mimic();
    conclude();
  end
endmodule // testbench
bind t1_superframe_alignment_search sf_align_checker sf_align_checker_i (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in),
  .framer_bypass_in(framer_bypass_in), .mimic_clear_in(mimic_clear_in),
  .data_ready_in(data_ready_in), .data_valid_out(data_valid_out),
  .data_bit_out(data_bit_out), .framing_bit_flag_out(framing_bit_flag_out),
  .multiframe_boundary_flag_out(multiframe_boundary_flag_out),
  .framing_error_out(framing_error_out),
  .out_of_frame_status_out(out_of_frame_status_out),
  .mimic_present_flag_out(mimic_present_flag_out));
